// >>> wdt_pkg.sv
// Constants, field layouts and types for the windowed watchdog timer
`default_nettype none

package wdt_pkg;

   // ==========================================================
   // Register bus geometry and offsets
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFF_CLEAR = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h1;
   localparam logic [3:0] OFF_COUNT_LO = 4'h2;
   localparam logic [3:0] OFF_COUNT_HI = 4'h3;
   localparam logic [3:0] OFF_FLAG_CLR = 4'h4;
   localparam logic [3:0] OFF_OPTION = 4'h5;

   // ==========================================================
   // Codes seen on the clear register
   localparam logic [7:0] CLEAR_CODE = 8'hac;
   localparam logic [7:0] READ_ENABLED = 8'h9a;
   localparam logic [7:0] READ_DISABLED = 8'h1a;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ==========================================================
   // Option byte field positions
   localparam int OPT_IRQ_BIT = 7;
   localparam int OPT_WIN_HI = 6;
   localparam int OPT_WIN_LO = 5;
   localparam int OPT_EN_BIT = 4;
   localparam int OPT_OVF_HI = 3;
   localparam int OPT_OVF_LO = 1;
   localparam int OPT_STBY_BIT = 0;
   localparam logic [7:0] OPT_RESET = 8'h00;

   // ==========================================================
   // Window select encodings
   localparam logic [1:0] WIN_PROHIBITED = 2'h0;
   localparam logic [1:0] WIN_50 = 2'h1;
   localparam logic [1:0] WIN_75 = 2'h2;
   localparam logic [1:0] WIN_100 = 2'h3;

   // ==========================================================
   // Status register bit positions
   localparam int STAT_FLAG = 0;
   localparam int STAT_OPEN = 1;
   localparam int STAT_FIRST = 2;
   localparam int STAT_RUN = 3;
   localparam int STAT_TRIP = 4;
   localparam int STAT_CNT_TOP = 5;
   localparam int FLAG_CLR_BIT = 0;

   // ==========================================================
   // Counter geometry
   localparam int CNT_W = 17;
   localparam int SHIFT_W = 5;
   localparam logic [16:0] CNT_ZERO = 17'h0_0000;
   localparam logic [16:0] CNT_ONE = 17'h0_0001;

   // Control flow of the watchdog
   typedef enum logic [1:0] {ST_LOAD, ST_STOPPED, ST_RUN, ST_TRIPPED} wdt_state_t;

   // Overflow exponent for each overflow select code
   function automatic logic [4:0] ovf_shift(input logic [2:0] code);
      logic [4:0] s;
      s = 5'h06;
      unique case (code)
         3'h0: s = 5'h06;
         3'h1: s = 5'h07;
         3'h2: s = 5'h08;
         3'h3: s = 5'h09;
         3'h4: s = 5'h0b;
         3'h5: s = 5'h0d;
         3'h6: s = 5'h0e;
         3'h7: s = 5'h10;
      endcase
      return s;
   endfunction

endpackage

`default_nettype wire

// >>> windowed_watchdog_timer.sv
// Windowed watchdog timer with option byte, clear register and interval interrupt
//
// The address map and the address-and-strobe port were left to the implementer.
`default_nettype none

// Function
// - Window select from option bits 6:5
// - 00 prohibited; 01=50%, 10=75%, 11=100%
// - Clear code in open window restarts counter
// - Clear code in closed window requests reset
// - First clear code after reset always clears
// - Standby option zero forces fully open window
// - Overflow 2^6..2^16 low-speed periods by code
// - Interval interrupt at 75% plus half period
// - Interval option zero: never any interrupt
// - Counting continues after interrupt; overflow resets
// - Any other written value requests reset
// - Single-bit access to clear register resets
// - Clear register reads 9A or 1A
// - Counting starts only when enable option set

// Behaviour worth knowing
// A clear write on the overflow edge wins; no reset request.
// The option byte is taken once, in the first cycle after reset.
// Clear writes in that first cycle are ignored.
// Window setting 00 behaves as a fully open window.
// Standby without the run option freezes the count, clears it on exit.
// The interval flag set wins over a software clear in one cycle.

module windowed_watchdog_timer #(
   parameter int ADDR_W = wdt_pkg::ADDR_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Option byte, stable while reset is high and after
   input wire logic [7:0] option_byte,
   // Low-speed oscillator clock, sampled as a level
   input wire logic il_clk,
   // Standby mode indication (halt, stop or snooze)
   input wire logic standby_mode,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic bit_access,
   output logic [7:0] rdata,
   // Results
   output logic interval_irq,
   output logic interval_irq_flag,
   output logic reset_req
);

   // ==========================================================
   // Declarations
   wdt_pkg::wdt_state_t state;
   wdt_pkg::wdt_state_t next_state;
   logic [7:0] option;
   logic [wdt_pkg::CNT_W-1:0] count;
   logic il_q;
   logic standby_q;
   logic first_done;
   logic irq_done;
   logic [1:0] window_select;
   logic [2:0] overflow_select;
   logic interval_irq_option;
   logic count_enable_option;
   logic standby_run_option;
   logic [wdt_pkg::CNT_W-1:0] limit;
   logic [wdt_pkg::CNT_W-1:0] closed_end;
   logic [wdt_pkg::CNT_W-1:0] irq_point;
   logic window_open;
   logic il_rise;
   logic il_fall;
   logic paused;
   logic standby_exit;
   logic clear_sel;
   logic clear_wr;
   logic good_clear;
   logic bad_write;
   logic closed_clear;
   logic do_clear;
   logic overflow;
   logic trip;
   logic irq_hit;
   logic flag_clr;
   logic [wdt_pkg::CNT_W-1:0] half_limit;
   logic [wdt_pkg::CNT_W-1:0] quarter_limit;
   logic count_step;
   logic at_last;
   logic [7:0] status_word;
   logic [7:0] next_rdata;

   // ==========================================================
   // Option byte fields
   assign window_select = option[wdt_pkg::OPT_WIN_HI:wdt_pkg::OPT_WIN_LO];
   assign overflow_select = option[wdt_pkg::OPT_OVF_HI:wdt_pkg::OPT_OVF_LO];
   assign interval_irq_option = option[wdt_pkg::OPT_IRQ_BIT];
   assign count_enable_option = option[wdt_pkg::OPT_EN_BIT];
   assign standby_run_option = option[wdt_pkg::OPT_STBY_BIT];

   // Option byte is captured on the first clock after reset release
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         option <= wdt_pkg::OPT_RESET;
      end else if (state == wdt_pkg::ST_LOAD) begin
         option <= option_byte;
      end
   end

   // ==========================================================
   // Control state machine
   always_comb begin
      next_state = state;
      unique case (state)
         wdt_pkg::ST_LOAD: begin
            if (option_byte[wdt_pkg::OPT_EN_BIT]) begin
               next_state = wdt_pkg::ST_RUN;
            end else begin
               next_state = wdt_pkg::ST_STOPPED;
            end
         end
         wdt_pkg::ST_STOPPED: begin
            if (trip) begin
               next_state = wdt_pkg::ST_TRIPPED;
            end
         end
         wdt_pkg::ST_RUN: begin
            if (trip) begin
               next_state = wdt_pkg::ST_TRIPPED;
            end
         end
         wdt_pkg::ST_TRIPPED: begin
            next_state = wdt_pkg::ST_TRIPPED;
         end
      endcase
   end

   // State register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state <= wdt_pkg::ST_LOAD;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // Low-speed clock edges and standby tracking
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         il_q <= 1'b0;
      end else begin
         il_q <= il_clk;
      end
   end

   // Previous standby level, for the exit edge
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         standby_q <= 1'b0;
      end else begin
         standby_q <= standby_mode;
      end
   end

   // Edges of the low-speed clock against its last sample
   assign il_rise = il_clk & ~il_q;
   assign il_fall = ~il_clk & il_q;
   // Counter freezes in standby unless the run option is set
   assign paused = standby_mode & ~standby_run_option;
   assign standby_exit = standby_q & ~standby_mode & ~standby_run_option;

   // ==========================================================
   // Limits and window boundaries
   assign limit = wdt_pkg::CNT_ONE << wdt_pkg::ovf_shift(overflow_select);

   // Window fractions of the overflow limit
   assign half_limit = limit >> 1;
   assign quarter_limit = limit >> 2;

   // Closed span runs from zero; open span runs up to overflow
   always_comb begin
      closed_end = wdt_pkg::CNT_ZERO;
      if (standby_run_option) begin
         unique case (window_select)
            wdt_pkg::WIN_50: closed_end = half_limit;
            wdt_pkg::WIN_75: closed_end = quarter_limit;
            wdt_pkg::WIN_100: closed_end = wdt_pkg::CNT_ZERO;
            wdt_pkg::WIN_PROHIBITED: closed_end = wdt_pkg::CNT_ZERO;
         endcase
      end
   end

   // Open window test and the 75% interrupt point
   assign window_open = (count >= closed_end);
   assign irq_point = limit - quarter_limit;

   // ==========================================================
   // Clear register write decoding
   assign clear_sel = (addr == wdt_pkg::OFF_CLEAR[ADDR_W-1:0]);
   assign clear_wr = wr & clear_sel & (state != wdt_pkg::ST_LOAD);
   assign good_clear = clear_wr & ~bit_access & (wdata == wdt_pkg::CLEAR_CODE);
   assign bad_write = clear_wr & (bit_access | (wdata != wdt_pkg::CLEAR_CODE));
   assign closed_clear = good_clear & first_done & ~window_open;
   assign do_clear = good_clear & (~first_done | window_open);

   // One counting step per low-speed rising edge while running and not paused by standby
   assign count_step = (state == wdt_pkg::ST_RUN) & il_rise & ~paused;
   assign at_last = (count == limit - wdt_pkg::CNT_ONE);

   // Overflow when the last count is passed without a clear
   assign overflow = count_step & at_last & ~do_clear;
   assign trip = bad_write | closed_clear | overflow;

   // First write after release is exempt from the window
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         first_done <= 1'b0;
      end else if (good_clear) begin
         first_done <= 1'b1;
      end
   end

   // ==========================================================
   // Watchdog counter
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         count <= wdt_pkg::CNT_ZERO;
      end else if (state != wdt_pkg::ST_RUN) begin
         count <= count;
      end else if (do_clear | standby_exit) begin
         count <= wdt_pkg::CNT_ZERO;
      end else if (count_step & ~overflow) begin
         count <= count + wdt_pkg::CNT_ONE;
      end
   end

   // ==========================================================
   // Interval interrupt, half a low-speed period after the 75% point
   assign irq_hit = (state == wdt_pkg::ST_RUN) & interval_irq_option & il_fall & ~paused &
                    ~irq_done & (count >= irq_point);

   // One interrupt per count period; re-armed by a clear
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         irq_done <= 1'b0;
      end else if (irq_hit) begin
         irq_done <= 1'b1;
      end else if (do_clear | standby_exit) begin
         irq_done <= 1'b0;
      end
   end

   // Interrupt pulse
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         interval_irq <= 1'b0;
      end else begin
         interval_irq <= irq_hit;
      end
   end

   // Sticky request flag; a new event wins over a software clear
   assign flag_clr = wr & ~bit_access & (addr == wdt_pkg::OFF_FLAG_CLR[ADDR_W-1:0]) &
                     wdata[wdt_pkg::FLAG_CLR_BIT];

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         interval_irq_flag <= 1'b0;
      end else if (irq_hit) begin
         interval_irq_flag <= 1'b1;
      end else if (flag_clr) begin
         interval_irq_flag <= 1'b0;
      end
   end

   // ==========================================================
   // Internal reset request, held until the system reset arrives
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         reset_req <= 1'b0;
      end else if (trip & (state != wdt_pkg::ST_TRIPPED)) begin
         reset_req <= 1'b1;
      end
   end

   // ==========================================================
   // Status bits placed by their named positions
   always_comb begin
      status_word = wdt_pkg::READ_ZERO;
      status_word[wdt_pkg::STAT_FLAG] = interval_irq_flag;
      status_word[wdt_pkg::STAT_OPEN] = window_open;
      status_word[wdt_pkg::STAT_FIRST] = first_done;
      status_word[wdt_pkg::STAT_RUN] = (state == wdt_pkg::ST_RUN);
      status_word[wdt_pkg::STAT_TRIP] = (state == wdt_pkg::ST_TRIPPED);
      status_word[wdt_pkg::STAT_CNT_TOP] = count[wdt_pkg::CNT_W-1];
   end

   // Read multiplexer, valid the cycle after the read strobe; idle reads zero
   always_comb begin
      next_rdata = wdt_pkg::READ_ZERO;
      if (rd) begin
         unique case (addr)
            wdt_pkg::OFF_CLEAR[ADDR_W-1:0]: begin
               next_rdata = count_enable_option ? wdt_pkg::READ_ENABLED
                                                : wdt_pkg::READ_DISABLED;
            end
            wdt_pkg::OFF_STATUS[ADDR_W-1:0]: begin
               next_rdata = status_word;
            end
            wdt_pkg::OFF_COUNT_LO[ADDR_W-1:0]: begin
               next_rdata = count[7:0];
            end
            wdt_pkg::OFF_COUNT_HI[ADDR_W-1:0]: begin
               next_rdata = count[15:8];
            end
            wdt_pkg::OFF_OPTION[ADDR_W-1:0]: begin
               next_rdata = option;
            end
            default: begin
               next_rdata = wdt_pkg::READ_ZERO;
            end
         endcase
      end
   end

   // Read data register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdata <= wdt_pkg::READ_ZERO;
      end else begin
         rdata <= next_rdata;
      end
   end

endmodule

`default_nettype wire

// >>> wdt_checker_asserts.sv
// Port-level property checker for the windowed watchdog timer
`default_nettype none

module wdt_checker #(
   parameter int ADDR_W = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Configuration and register port
   input wire logic [7:0] option_byte,
   input wire logic il_clk,
   input wire logic standby_mode,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic bit_access,
   input wire logic [7:0] rdata,
   // Results
   input wire logic interval_irq,
   input wire logic interval_irq_flag,
   input wire logic reset_req
);
   timeunit 1ns;
   timeprecision 1ns;
   logic loaded;
   logic first_done;
   logic clr_wr;
   logic good_clr;

   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   // ==========================================================
   // Helper logic
   // Clear register writes once the option byte is loaded
   assign clr_wr = loaded && wr && addr == ADDR_W'(wdt_pkg::OFF_CLEAR);
   assign good_clr = clr_wr && !bit_access && wdata == wdt_pkg::CLEAR_CODE && !reset_req;

   // Load cycle and first clear write seen
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         loaded <= 1'b0;
         first_done <= 1'b0;
      end else begin
         loaded <= 1'b1;
         if (clr_wr) begin
            first_done <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Properties
   property p_bad_code;
      clr_wr && wdata != wdt_pkg::CLEAR_CODE |=> reset_req;
   endproperty
   a_bad_code: assert property (p_bad_code) else $error("bad code did not trip");

   property p_bit_access;
      clr_wr && bit_access |=> reset_req;
   endproperty
   a_bit_access: assert property (p_bit_access) else $error("bit access did not trip");

   property p_sticky;
      $rose(reset_req) |-> reset_req [*8];
   endproperty
   a_sticky: assert property (p_sticky) else $error("reset request dropped");

   property p_read_code;
      loaded && rd && addr == ADDR_W'(wdt_pkg::OFF_CLEAR) |=> rdata == (option_byte[wdt_pkg::OPT_EN_BIT]
         ? wdt_pkg::READ_ENABLED : wdt_pkg::READ_DISABLED);
   endproperty
   a_read_code: assert property (p_read_code) else $error("clear register read wrong");

   property p_no_irq;
      !option_byte[wdt_pkg::OPT_IRQ_BIT] |-> !interval_irq && !interval_irq_flag;
   endproperty
   a_no_irq: assert property (p_no_irq) else $error("interrupt while disabled");

   property p_irq_flag;
      interval_irq |=> !interval_irq && interval_irq_flag;
   endproperty
   a_irq_flag: assert property (p_irq_flag) else $error("interrupt pulse or flag wrong");

   property p_first_free;
      good_clr && !first_done |=> !reset_req;
   endproperty
   a_first_free: assert property (p_first_free) else $error("first clear tripped");

   property p_standby_open;
      good_clr && !option_byte[wdt_pkg::OPT_STBY_BIT] |=> !reset_req;
   endproperty
   a_standby_open: assert property (p_standby_open) else $error("forced open tripped");

   property p_full_open;
      good_clr && option_byte[6:5] == wdt_pkg::WIN_100 |=> !reset_req;
   endproperty
   a_full_open: assert property (p_full_open) else $error("full window tripped");

   // Main scenarios reached
   c_clear: cover property (good_clr && first_done ##1 !reset_req);
   c_irq: cover property (interval_irq);
   c_trip: cover property ($rose(reset_req));
endmodule

bind windowed_watchdog_timer wdt_checker #(.ADDR_W(ADDR_W)) chk_u (.mclk(mclk), .reset(reset),
   .option_byte(option_byte), .il_clk(il_clk), .standby_mode(standby_mode), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .bit_access(bit_access), .rdata(rdata),
   .interval_irq(interval_irq), .interval_irq_flag(interval_irq_flag), .reset_req(reset_req));

`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the windowed watchdog timer
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, reset, il_clk, standby_mode, wr, rd, bit_access;
   logic interval_irq, interval_irq_flag, reset_req, e;
   logic [7:0] option_byte, wdata, rdata, v;
   logic [3:0] addr;
   logic [1:0] il_div;
   logic [15:0] cnt;
   logic [31:0] seed;
   int failures, checked, pulses, lim;
   int ex[4] = '{6, 7, 8, 9};

   windowed_watchdog_timer dut_u (.mclk(mclk), .reset(reset), .option_byte(option_byte),
      .il_clk(il_clk), .standby_mode(standby_mode), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .bit_access(bit_access), .rdata(rdata), .interval_irq(interval_irq),
      .interval_irq_flag(interval_irq_flag), .reset_req(reset_req));

   // System clock and a slow clock of four cycles
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      il_div <= il_div + 2'h1;
      il_clk <= il_div[1];
      if (interval_irq === 1'b1) pulses <= pulses + 1;
   end

   function automatic logic [31:0] nxt(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   // Clear write lands in a closed window (64 count limit)
   function automatic logic trip_exp(input int w, input int s, input int d);
      return s == 1 && ((w == 1 && d < 32) || (w == 2 && d < 16));
   endfunction

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic start(input logic [7:0] opt);
      @(posedge mclk);
      reset <= 1'b1;
      option_byte <= opt;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask

   // One bus cycle: write when w is high, else read into v
   task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w, input logic b);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      bit_access <= b;
      @(posedge mclk);
      wr <= 1'b0;
      rd <= 1'b0;
      bit_access <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic periods(input int n);
      repeat (4 * n) @(posedge mclk);
   endtask

   task automatic get_count;
      bus(4'h2, 8'h00, 1'b0, 1'b0);
      cnt[7:0] = v;
      bus(4'h3, 8'h00, 1'b0, 1'b0);
      cnt[15:8] = v;
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #6_000_000;
      failures++;
      summarize();
   end

   initial begin
      {reset, option_byte, standby_mode, addr, wdata, wr, rd, bit_access} = '0;
      reset = 1'b1;
      {il_div, il_clk, failures, checked, pulses} = '0;
      seed = 32'h0000_0008;
      // Every legal window code and standby option, second clear after 10 or 50 periods
      for (int s = 0; s < 2; s++) begin
         for (int w = 1; w < 4; w++) begin
            for (int d = 10; d < 60; d += 40) begin
               start({1'b0, 2'(w), 1'b1, 3'h0, 1'(s)});
               e = trip_exp(w, s, d);
               bus(4'h0, 8'h00, 1'b0, 1'b0);
               check("clear_read", 16'(v), 16'h009a);
               periods(3);
               bus(4'h0, 8'hac, 1'b1, 1'b0);
               periods(d);
               bus(4'h0, 8'hac, 1'b1, 1'b0);
               get_count;
               check("window_trip", 16'(reset_req), 16'(e));
               if (!e) check("cleared", 16'(cnt <= 16'h0002), 16'h0001);
            end
         end
      end
      $display("window test done");
      // Interval interrupt on and off, then overflow
      for (int i = 0; i < 2; i++) begin
         seed = nxt(seed);
         lim = 1 << ex[seed[1:0]];
         start({1'(i), 2'h3, 1'b1, 1'b0, seed[1:0], 1'b1});
         bus(4'h0, 8'hac, 1'b1, 1'b0);
         pulses = 0;
         periods(lim * 3 / 4 - 3);
         check("early_flag", 16'(interval_irq_flag), 16'h0000);
         periods(7);
         check("flag", 16'(interval_irq_flag), 16'(i));
         check("pulses", 16'(pulses), 16'(i));
         bus(4'h4, 8'h01, 1'b1, 1'b0);
         bus(4'h1, 8'h00, 1'b0, 1'b0);
         check("status", 16'(v[5:0]), 16'h000e);
         get_count;
         check("counting", 16'(cnt >= 16'(lim * 3 / 4)), 16'h0001);
         check("no_trip", 16'(reset_req), 16'h0000);
         periods(lim / 4);
         check("overflow", 16'(reset_req), 16'h0001);
      end
      $display("interval test done");
      // Bit access, then random wrong codes
      for (int i = 0; i < 6; i++) begin
         seed = nxt(seed);
         start(8'h7f);
         bus(4'h0, 8'hac, 1'b1, 1'b0);
         v = (seed[7:0] == 8'hac) ? 8'h9a : seed[7:0];
         bus(4'h0, (i == 0) ? 8'hac : v, 1'b1, i == 0);
         @(posedge mclk);
         check("bad_write", 16'(reset_req), 16'h0001);
      end
      $display("bad write test done");
      // Counting disabled by option
      start(8'h6f);
      bus(4'h0, 8'h00, 1'b0, 1'b0);
      check("clear_read", 16'(v), 16'h001a);
      periods(20);
      get_count;
      check("stopped", cnt, 16'h0000);
      bus(4'h5, 8'h00, 1'b0, 1'b0);
      check("option", 16'(v), 16'h006f);
      $display("disabled test done");
      // Standby without the run option freezes, then restarts the count
      start(8'h5e);
      periods(10);
      standby_mode <= 1'b1;
      get_count;
      lim = cnt;
      periods(10);
      get_count;
      check("frozen", cnt, 16'(lim));
      @(posedge mclk);
      standby_mode <= 1'b0;
      periods(2);
      get_count;
      check("standby_exit", 16'(cnt <= 16'h0003), 16'h0001);
      bus(4'h0, 8'hac, 1'b1, 1'b0);
      bus(4'h0, 8'hac, 1'b1, 1'b0);
      @(posedge mclk);
      check("standby_open", 16'(reset_req), 16'h0000);
      $display("standby test done");
      summarize();
   end
endmodule

`default_nettype wire
